// >>> mbsrv_pkg.sv
// constants and types shared by the modbus read and coil write server
package mbsrv_pkg;
  // ******************************
  // function and exception codes
  // ******************************
  localparam logic [7:0] FC_READ_COILS = 8'h01;
  localparam logic [7:0] FC_READ_DISCRETE = 8'h02;
  localparam logic [7:0] FC_READ_HOLDING = 8'h03;
  localparam logic [7:0] FC_READ_INPUT_REGS = 8'h04;
  localparam logic [7:0] FC_WRITE_COIL = 8'h05;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
  // ******************************
  // field values and limits
  // ******************************
  localparam logic [15:0] COIL_ON = 16'hFF00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  localparam logic [15:0] MAX_BIT_QTY = 16'h07D0;
  localparam logic [15:0] MAX_REG_QTY = 16'h007D;
  // ******************************
  // request byte positions (mbap header then pdu)
  // ******************************
  localparam logic [3:0] POS_TXN_HI = 4'h0;
  localparam logic [3:0] POS_TXN_LO = 4'h1;
  localparam logic [3:0] POS_PROTO_HI = 4'h2;
  localparam logic [3:0] POS_PROTO_LO = 4'h3;
  localparam logic [3:0] POS_UNIT = 4'h6;
  localparam logic [3:0] POS_FUNC = 4'h7;
  localparam logic [3:0] POS_ADDR_HI = 4'h8;
  localparam logic [3:0] POS_ADDR_LO = 4'h9;
  localparam logic [3:0] POS_QTY_HI = 4'hA;
  localparam logic [3:0] POS_QTY_LO = 4'hB;
  localparam logic [3:0] MIN_REQ_LEN = 4'h8;
  localparam logic [3:0] FULL_REQ_LEN = 4'hC;
  // ******************************
  // response layout
  // ******************************
  localparam logic [8:0] RESP_FIRST_DATA = 9'h009;
  localparam logic [8:0] RESP_HDR_BEFORE_PDU = 9'h006;
  localparam logic [8:0] PDU_LEN_EXC = 9'h002;
  localparam logic [8:0] PDU_LEN_READ_HDR = 9'h002;
  localparam logic [8:0] PDU_LEN_WRITE_COIL = 9'h005;
  localparam logic [15:0] LEN_UNIT_BYTE = 16'h0001;
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_EXEC = 3'b010,
    S_SEND = 3'b100
  } mbsrv_state_t;
endpackage : mbsrv_pkg

// >>> mbsrv_req_if.sv
// request fields handed from the receive parser to the server core
`timescale 1ns/100ps
interface mbsrv_req_if;
  logic valid;
  logic taken;
  logic [3:0] count;
  logic [15:0] txn;
  logic [15:0] proto;
  logic [7:0] unit;
  logic [7:0] func;
  logic [15:0] addr;
  logic [15:0] qty;
  modport parser (output valid, count, txn, proto, unit, func, addr, qty, input taken);
  modport server (input valid, count, txn, proto, unit, func, addr, qty, output taken);
endinterface : mbsrv_req_if

// >>> mbsrv_rx_parser.sv
// collects one request frame byte by byte and holds its fields
`timescale 1ns/100ps
module mbsrv_rx_parser (
  input wire logic mclk,
  input wire logic rst,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxLast,
  output logic rxReady,
  mbsrv_req_if.parser req
);
  import mbsrv_pkg::*;

  logic pend, next_pend;
  logic ready, next_ready;
  logic [3:0] cnt, next_cnt;
  logic [15:0] txn, next_txn, proto, next_proto, addr, next_addr, qty, next_qty;
  logic [7:0] unit, next_unit, func, next_func;
  logic [3:0] held, next_held;
  logic take;

  assign take = rxValid && ready;

  always_comb begin
    next_pend = pend;
    next_cnt = cnt;
    next_held = held;
    next_txn = txn;
    next_proto = proto;
    next_unit = unit;
    next_func = func;
    next_addr = addr;
    next_qty = qty;
    if (req.taken) begin
      next_pend = 1'b0;
    end
    if (take) begin
      case (cnt)
        POS_TXN_HI: next_txn[15:8] = rxData;
        POS_TXN_LO: next_txn[7:0] = rxData;
        POS_PROTO_HI: next_proto[15:8] = rxData;
        POS_PROTO_LO: next_proto[7:0] = rxData;
        POS_UNIT: next_unit = rxData;
        POS_FUNC: next_func = rxData;
        POS_ADDR_HI: next_addr[15:8] = rxData;
        POS_ADDR_LO: next_addr[7:0] = rxData;
        POS_QTY_HI: next_qty[15:8] = rxData;
        POS_QTY_LO: next_qty[7:0] = rxData;
        default: next_cnt = cnt;
      endcase
      // bytes past a full request are ignored, the count saturates
      next_cnt = (cnt == FULL_REQ_LEN) ? cnt : cnt + 4'h1;
      if (rxLast) begin
        next_held = next_cnt;
        next_cnt = 4'h0;
        next_pend = 1'b1;
      end
    end
    // no byte is taken while a request waits for its answer
    next_ready = !next_pend;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pend <= 1'b0;
      ready <= 1'b0;
      cnt <= 4'h0;
      held <= 4'h0;
      txn <= 16'h0000;
      proto <= 16'h0000;
      unit <= 8'h00;
      func <= 8'h00;
      addr <= 16'h0000;
      qty <= 16'h0000;
    end else begin
      pend <= next_pend;
      ready <= next_ready;
      cnt <= next_cnt;
      held <= next_held;
      txn <= next_txn;
      proto <= next_proto;
      unit <= next_unit;
      func <= next_func;
      addr <= next_addr;
      qty <= next_qty;
    end
  end

  assign rxReady = ready;
  assign req.valid = pend;
  assign req.count = held;
  assign req.txn = txn;
  assign req.proto = proto;
  assign req.unit = unit;
  assign req.func = func;
  assign req.addr = addr;
  assign req.qty = qty;
endmodule : mbsrv_rx_parser

// >>> mbsrv_server.sv
// modbus server core: tables, request checks and response byte stream
`timescale 1ns/100ps
// Behaviour
// - read coils addresses coils from zero
// - coil bit one means on, zero off
// - first coil in bit0, ascending bits, bytes
// - unused high bits of last byte zero
// - byte count precedes packed bit data
// - discrete inputs zero based, packed bit0 upward
// - discrete input padding bits are zero
// - read holding returns contiguous zero based block
// - each register sent high byte first
// - input registers read same big endian way
// - write coil FF00 sets, 0000 clears
// - other coil values leave output unchanged
// - write coil answer echoes request after update
// - exception sets function msb, normal echoes
// - copy transaction id, length counts unit byte
// - error answer for bad function, quantity, address
module mbsrv_server #(
  parameter int N_COILS = 16,
  parameter int N_DI = 16,
  parameter int N_HR = 16,
  parameter int N_IR = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxLast,
  output logic rxReady,
  output logic txValid,
  output logic [7:0] txData,
  output logic txLast,
  input wire logic txReady,
  output logic [N_COILS-1:0] coilState,
  input wire logic coilWrEn,
  input wire logic [15:0] coilWrAddr,
  input wire logic coilWrData,
  input wire logic [N_DI-1:0] diState,
  input wire logic hrWrEn,
  input wire logic [15:0] hrWrAddr,
  input wire logic [15:0] hrWrData,
  output logic [N_HR*16-1:0] hrState,
  input wire logic [N_IR*16-1:0] irState
);
  import mbsrv_pkg::*;

  localparam int CW = (N_COILS > 1) ? $clog2(N_COILS) : 1;
  localparam int DW = (N_DI > 1) ? $clog2(N_DI) : 1;
  localparam int HW = (N_HR > 1) ? $clog2(N_HR) : 1;
  localparam int IW = (N_IR > 1) ? $clog2(N_IR) : 1;

  mbsrv_req_if req ();

  mbsrv_rx_parser u_parser (
    .mclk(mclk),
    .rst(rst),
    .rxValid(rxValid),
    .rxData(rxData),
    .rxLast(rxLast),
    .rxReady(rxReady),
    .req(req)
  );

  // ******************************
  // state
  // ******************************
  mbsrv_state_t state, next_state;
  logic [8:0] idx, next_idx;
  logic [8:0] pduLen, next_pduLen;
  logic [7:0] exc, next_exc;
  logic next_txValid, next_txLast;
  logic [7:0] next_txData;
  logic [N_COILS-1:0] coil, next_coil;
  logic [15:0] hreg [N_HR];
  logic [15:0] next_hreg [N_HR];
  logic [15:0] irArr [N_IR];

  logic isBits, isRegs, isWc, isCoilRd, isHold;
  logic [16:0] endAddr, tblSize;
  logic [7:0] chkExc;
  logic [8:0] chkPduLen, lastIdx;
  logic [7:0] bitCount;
  logic [8:0] k;
  logic [7:0] packBits;
  logic [16:0] rLoc;
  logic [15:0] regWord;
  logic [15:0] lenVal;
  logic advance;

  assign isBits = (req.func == FC_READ_COILS) || (req.func == FC_READ_DISCRETE);
  assign isRegs = (req.func == FC_READ_HOLDING) || (req.func == FC_READ_INPUT_REGS);
  assign isWc = (req.func == FC_WRITE_COIL);
  assign isCoilRd = (req.func == FC_READ_COILS);
  assign isHold = (req.func == FC_READ_HOLDING);
  assign endAddr = 17'(req.addr) + 17'(req.qty);
  assign bitCount = 8'((17'(req.qty) + 17'h00007) >> 3);
  assign lenVal = 16'(pduLen) + LEN_UNIT_BYTE;
  assign lastIdx = pduLen + RESP_HDR_BEFORE_PDU;
  assign req.taken = ((state == S_SEND) && txReady && (idx == lastIdx))
    || ((state == S_IDLE) && req.valid && (req.count < MIN_REQ_LEN));

  // ******************************
  // request checks
  // ******************************
  always_comb begin
    tblSize = 17'(N_COILS);
    case (req.func)
      FC_READ_DISCRETE: tblSize = 17'(N_DI);
      FC_READ_HOLDING: tblSize = 17'(N_HR);
      FC_READ_INPUT_REGS: tblSize = 17'(N_IR);
      default: tblSize = 17'(N_COILS);
    endcase
    chkExc = EXC_NONE;
    if (!(isBits || isRegs || isWc)) begin
      chkExc = EXC_ILLEGAL_FUNC;
    end else if (req.count < FULL_REQ_LEN) begin
      chkExc = EXC_ILLEGAL_VALUE;
    end else if (isWc) begin
      if ((req.qty != COIL_ON) && (req.qty != COIL_OFF)) begin
        chkExc = EXC_ILLEGAL_VALUE;
      end else if (17'(req.addr) >= tblSize) begin
        chkExc = EXC_ILLEGAL_ADDR;
      end
    end else if ((req.qty == 16'h0000) || (req.qty > (isBits ? MAX_BIT_QTY : MAX_REG_QTY))) begin
      chkExc = EXC_ILLEGAL_VALUE;
    end else if (endAddr > tblSize) begin
      chkExc = EXC_ILLEGAL_ADDR;
    end
    if (chkExc != EXC_NONE) begin
      chkPduLen = PDU_LEN_EXC;
    end else if (isWc) begin
      chkPduLen = PDU_LEN_WRITE_COIL;
    end else if (isBits) begin
      chkPduLen = PDU_LEN_READ_HDR + 9'(bitCount);
    end else begin
      chkPduLen = PDU_LEN_READ_HDR + {req.qty[7:0], 1'b0};
    end
  end

  // ******************************
  // sequencing and table updates
  // ******************************
  always_comb begin
    next_state = state;
    next_idx = idx;
    next_pduLen = pduLen;
    next_exc = exc;
    next_txValid = txValid;
    next_coil = coil;
    next_hreg = hreg;
    if (hrWrEn && (17'(hrWrAddr) < 17'(N_HR))) begin
      next_hreg[hrWrAddr[HW-1:0]] = hrWrData;
    end
    if (coilWrEn && (17'(coilWrAddr) < 17'(N_COILS))) begin
      next_coil[coilWrAddr[CW-1:0]] = coilWrData;
    end
    case (state)
      S_IDLE: begin
        if (req.valid && (req.count >= MIN_REQ_LEN)) begin
          next_state = S_EXEC;
        end
      end
      S_EXEC: begin
        next_exc = chkExc;
        next_pduLen = chkPduLen;
        // a bus write wins over a device-side write in the same cycle
        if ((chkExc == EXC_NONE) && isWc) begin
          next_coil[req.addr[CW-1:0]] = (req.qty == COIL_ON);
        end
        next_idx = 9'h000;
        next_txValid = 1'b1;
        next_state = S_SEND;
      end
      S_SEND: begin
        if (txReady) begin
          if (idx == lastIdx) begin
            next_txValid = 1'b0;
            next_state = S_IDLE;
          end else begin
            next_idx = idx + 9'h001;
          end
        end
      end
      default: next_state = S_IDLE;
    endcase
    next_txLast = next_txValid && (next_idx == (next_pduLen + RESP_HDR_BEFORE_PDU));
  end

  // ******************************
  // response data for the next byte
  // ******************************
  assign k = next_idx - RESP_FIRST_DATA;
  assign advance = (state == S_EXEC) || ((state == S_SEND) && txReady);

  genvar gb;
  generate
    for (gb = 0; gb < 8; gb++) begin : g_bit
      logic [16:0] pos;
      logic [16:0] loc;
      assign pos = 17'({k, 3'b000}) + 17'(gb);
      assign loc = 17'(req.addr) + pos;
      // bits past the quantity stay zero
      assign packBits[gb] = (pos < 17'(req.qty)) && (isCoilRd ?
        ((loc < 17'(N_COILS)) && coil[loc[CW-1:0]]) :
        ((loc < 17'(N_DI)) && diState[loc[DW-1:0]]));
    end
    for (gb = 0; gb < N_IR; gb++) begin : g_ir
      assign irArr[gb] = irState[gb*16 +: 16];
    end
    for (gb = 0; gb < N_HR; gb++) begin : g_hr
      assign hrState[gb*16 +: 16] = hreg[gb];
    end
  endgenerate

  assign rLoc = 17'(req.addr) + 17'(k[8:1]);
  always_comb begin
    regWord = 16'h0000;
    if (isHold && (rLoc < 17'(N_HR))) begin
      regWord = hreg[rLoc[HW-1:0]];
    end else if (!isHold && (rLoc < 17'(N_IR))) begin
      regWord = irArr[rLoc[IW-1:0]];
    end
  end

  always_comb begin
    next_txData = txData;
    case (next_idx)
      9'h000: next_txData = req.txn[15:8];
      9'h001: next_txData = req.txn[7:0];
      9'h002: next_txData = req.proto[15:8];
      9'h003: next_txData = req.proto[7:0];
      9'h004: next_txData = lenVal[15:8];
      9'h005: next_txData = lenVal[7:0];
      9'h006: next_txData = req.unit;
      9'h007: next_txData = (exc != EXC_NONE) ? (req.func | EXC_FLAG) : req.func;
      9'h008: begin
        if (exc != EXC_NONE) begin
          next_txData = exc;
        end else if (isWc) begin
          next_txData = req.addr[15:8];
        end else if (isBits) begin
          next_txData = bitCount;
        end else begin
          next_txData = {req.qty[6:0], 1'b0};
        end
      end
      default: begin
        if (isWc) begin
          // echo of address low, value high, value low
          case (k[1:0])
            2'h0: next_txData = req.addr[7:0];
            2'h1: next_txData = req.qty[15:8];
            default: next_txData = req.qty[7:0];
          endcase
        end else if (isBits) begin
          next_txData = packBits;
        end else begin
          next_txData = k[0] ? regWord[7:0] : regWord[15:8];
        end
      end
    endcase
    // a stalled byte keeps its value even if a table behind it moves
    if (!advance) begin
      next_txData = txData;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= S_IDLE;
      idx <= 9'h000;
      pduLen <= 9'h000;
      exc <= EXC_NONE;
      txValid <= 1'b0;
      txLast <= 1'b0;
      txData <= 8'h00;
      coil <= '0;
      for (int i = 0; i < N_HR; i++) begin
        hreg[i] <= 16'h0000;
      end
    end else begin
      state <= next_state;
      idx <= next_idx;
      pduLen <= next_pduLen;
      exc <= next_exc;
      txValid <= next_txValid;
      txLast <= next_txLast;
      txData <= next_txData;
      coil <= next_coil;
      hreg <= next_hreg;
    end
  end

  assign coilState = coil;
endmodule : mbsrv_server

// >>> mbsrv_chk.sv
// assertions on the server's request, response and coil table ports
`timescale 1ns/100ps
module mbsrv_chk #(
  parameter int N_COILS = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic rxValid,
  input wire logic rxLast,
  input wire logic rxReady,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txLast,
  input wire logic txReady,
  input wire logic [N_COILS-1:0] coilState,
  input wire logic coilWrEn,
  input wire logic [15:0] coilWrAddr,
  input wire logic coilWrData
);
  // ****
  // frame length tracking
  // ****
  logic take;
  logic [3:0] nBytes;
  logic [3:0] next_nBytes;
  assign take = rxValid && rxReady;
  // saturates so an overlong frame still counts as full
  always_comb begin
    next_nBytes = nBytes;
    if (take) begin
      next_nBytes = rxLast ? 4'h0 : (nBytes == 4'hF ? nBytes : nBytes + 4'h1);
    end
  end
  always_ff @(posedge mclk) begin
    nBytes <= rst ? 4'h0 : next_nBytes;
  end
  // ****
  // properties
  // ****
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_rst_quiet; $fell(rst) |-> !txValid && !rxReady && coilState == '0; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("reset state wrong");
  property p_ready_up; $fell(rst) |=> rxReady; endproperty
  a_ready_up: assert property (p_ready_up) else $error("not ready after reset");
  property p_full_answer; take && rxLast && nBytes >= 4'h7 |=> !rxReady && !txValid
    ##1 !txValid ##1 txValid;
  endproperty
  a_full_answer: assert property (p_full_answer) else $error("answer timing");
  property p_short_drop; take && rxLast && nBytes < 4'h7 |=> !txValid [*4]; endproperty
  a_short_drop: assert property (p_short_drop) else $error("short frame answered");
  property p_tx_hold; txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("byte dropped in stall");
  property p_one_at_time; txValid |-> !rxReady; endproperty
  a_one_at_time: assert property (p_one_at_time) else $error("ready during answer");
  property p_ready_back; txValid && txReady && txLast |=> !txValid ##1 rxReady; endproperty
  a_ready_back: assert property (p_ready_back) else $error("no ready after answer");
  property p_dev_coil; coilWrEn && rxReady && coilWrAddr < N_COILS
    |=> coilState[$past(coilWrAddr)] == $past(coilWrData); endproperty
  a_dev_coil: assert property (p_dev_coil) else $error("device coil write lost");
  property p_coil_hold; !coilWrEn && rxReady |=> $stable(coilState); endproperty
  a_coil_hold: assert property (p_coil_hold) else $error("coil changed idle");
endmodule : mbsrv_chk

// >>> mbsrv_client.sv
// remote client stand-in: sends one request frame and collects the answer
`timescale 1ns/100ps
module mbsrv_client (
  input wire logic mclk,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxLast,
  input wire logic rxReady,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txLast,
  output logic txReady
);
  logic [7:0] resp[$];
  bit lastSeen;
  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
    rxLast = 1'b0;
    txReady = 1'b0;
  end
  // stall > 0 drops ready one cycle in stall+1; gives up after 200 cycles
  task automatic transact(input logic [7:0] req[$], input int stall);
    int n;
    bit done;
    resp.delete();
    foreach (req[i]) begin
      @(negedge mclk);
      rxValid = 1'b1;
      rxData = req[i];
      rxLast = (i == req.size() - 1);
      n = 0;
      do begin
        @(posedge mclk);
        n++;
      end while (rxReady !== 1'b1 && n < 200);
    end
    @(negedge mclk);
    rxValid = 1'b0;
    rxLast = 1'b0;
    // a released data line must not keep showing the last byte
    rxData = ~rxData;
    done = 1'b0;
    for (n = 0; n < 200 && !done; n++) begin
      txReady = (stall == 0) || (n % (stall + 1) != 0);
      @(posedge mclk);
      if (txValid === 1'b1 && txReady) begin
        resp.push_back(txData);
        done = (txLast === 1'b1);
      end
      @(negedge mclk);
    end
    lastSeen = done;
    txReady = 1'b0;
  endtask : transact
endmodule : mbsrv_client

// >>> testbench.sv
// self-checking bench for the modbus server core
`timescale 1ns/100ps
module testbench;
  import mbsrv_pkg::*;
  logic mclk, rst, rxValid, rxLast, rxReady, txValid, txLast, txReady;
  logic [7:0] rxData, txData;
  logic [15:0] coilState, diState, coilWrAddr, hrWrAddr, hrWrData, txn;
  logic coilWrEn, coilWrData, hrWrEn;
  logic [255:0] hrState, irState, hrExp;
  logic [7:0] exp[$];
  int miscompares, checks;
  mbsrv_server i_dut (.mclk(mclk), .rst(rst), .rxValid(rxValid), .rxData(rxData),
    .rxLast(rxLast), .rxReady(rxReady), .txValid(txValid), .txData(txData), .txLast(txLast),
    .txReady(txReady), .coilState(coilState), .coilWrEn(coilWrEn), .coilWrAddr(coilWrAddr),
    .coilWrData(coilWrData), .diState(diState), .hrWrEn(hrWrEn), .hrWrAddr(hrWrAddr),
    .hrWrData(hrWrData), .hrState(hrState), .irState(irState));
  mbsrv_client i_cli (.mclk(mclk), .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast),
    .rxReady(rxReady), .txValid(txValid), .txData(txData), .txLast(txLast), .txReady(txReady));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ****
  // shared helpers
  // ****
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask : check
  task automatic print_verdict();
    if (miscompares == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  task automatic dev_write(input bit hr, input logic [15:0] a, input logic [15:0] d);
    @(negedge mclk);
    coilWrEn = !hr;
    hrWrEn = hr;
    coilWrAddr = a;
    hrWrAddr = a;
    coilWrData = d[0];
    hrWrData = d;
    @(negedge mclk);
    coilWrEn = 1'b0;
    hrWrEn = 1'b0;
  endtask : dev_write
  task automatic bits_exp(input logic [15:0] v, input int a, input int q);
    exp = {8'((q + 7) / 8)};
    for (int i = 0; i < q; i++) begin
      if (i % 8 == 0) exp.push_back(8'h00);
      exp[exp.size() - 1][i % 8] = v[a + i];
    end
  endtask : bits_exp
  task automatic regs_exp(input logic [255:0] t, input int a, input int q);
    exp = {8'(2 * q)};
    for (int i = a; i < a + q; i++) begin
      exp.push_back(t[16 * i + 8 +: 8]);
      exp.push_back(t[16 * i +: 8]);
    end
  endtask : regs_exp
  // sends the first n bytes of a request; exp holds what follows the answer's function code
  task automatic xact(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] q,
      input logic [7:0] rfc, input int stall, input int n);
    logic [7:0] req[$];
    logic [7:0] want[$];
    txn = txn + 16'h0111;
    req = {txn[15:8], txn[7:0], 8'h00, 8'h00, 8'h00, 8'h06, 8'h11, fc,
      a[15:8], a[7:0], q[15:8], q[7:0]};
    req = req[0:n - 1];
    if (n >= 8) want = {txn[15:8], txn[7:0], 8'h00, 8'h00, 8'h00, 8'(exp.size() + 2), 8'h11,
      rfc, exp};
    i_cli.transact(req, stall);
    check(16'(i_cli.resp.size()), 16'(want.size()));
    check(16'(i_cli.lastSeen), 16'(want.size() != 0));
    foreach (want[i]) begin
      if (i < i_cli.resp.size()) check({8'h00, i_cli.resp[i]}, {8'h00, want[i]});
    end
  endtask : xact
  // ****
  // scenarios
  // ****
  task automatic t_coils();
    for (int i = 0; i < 16; i++) dev_write(1'b0, 16'(i), 16'(16'hA5C3 >> i));
    check(coilState, 16'hA5C3);
    bits_exp(16'hA5C3, 3, 10);
    xact(FC_READ_COILS, 16'h0003, 16'h000A, FC_READ_COILS, 1, 12);
  endtask : t_coils
  task automatic t_inputs();
    @(negedge mclk);
    diState = 16'h6B2D;
    bits_exp(16'h6B2D, 5, 11);
    xact(FC_READ_DISCRETE, 16'h0005, 16'h000B, FC_READ_DISCRETE, 0, 12);
    bits_exp(16'h6B2D, 0, 16);
    xact(FC_READ_DISCRETE, 16'h0000, 16'h0010, FC_READ_DISCRETE, 2, 12);
  endtask : t_inputs
  task automatic t_regs();
    logic [15:0] v;
    for (int i = 0; i < 4; i++) begin
      v = 16'hC0DE ^ 16'(i * 4369);
      dev_write(1'b1, 16'(i), v);
      hrExp[16 * i +: 16] = v;
    end
    check(hrState[63:48], hrExp[63:48]);
    regs_exp(hrExp, 1, 3);
    xact(FC_READ_HOLDING, 16'h0001, 16'h0003, FC_READ_HOLDING, 2, 12);
    @(negedge mclk);
    for (int i = 0; i < 16; i++) irState[16 * i +: 16] = 16'h9A10 + 16'(i * 257);
    regs_exp(irState, 14, 2);
    xact(FC_READ_INPUT_REGS, 16'h000E, 16'h0002, FC_READ_INPUT_REGS, 0, 12);
  endtask : t_regs
  task automatic t_wcoil();
    logic [15:0] vals[3] = '{COIL_ON, 16'h1234, COIL_OFF};
    for (int i = 0; i < 3; i++) begin
      if (i == 1) exp = {EXC_ILLEGAL_VALUE};
      else exp = {8'h00, 8'h04, vals[i][15:8], vals[i][7:0]};
      xact(FC_WRITE_COIL, 16'h0004, vals[i], i == 1 ? FC_WRITE_COIL | EXC_FLAG : FC_WRITE_COIL,
        1, 12);
      check(coilState, i < 2 ? 16'hA5D3 : 16'hA5C3);
    end
  endtask : t_wcoil
  task automatic t_exc();
    logic [7:0] fc[3] = '{8'h06, FC_READ_HOLDING, FC_READ_COILS};
    logic [15:0] ad[3] = '{16'h0000, 16'h0010, 16'h0000};
    logic [7:0] cd[3] = '{EXC_ILLEGAL_FUNC, EXC_ILLEGAL_ADDR, EXC_ILLEGAL_VALUE};
    for (int i = 0; i < 3; i++) begin
      exp = {cd[i]};
      xact(fc[i], ad[i], 16'(2 - i), fc[i] | EXC_FLAG, 0, 12);
    end
    exp = {EXC_ILLEGAL_VALUE};
    xact(FC_READ_HOLDING, 16'h0000, 16'h0001, FC_READ_HOLDING | EXC_FLAG, 0, 10);
    xact(FC_READ_HOLDING, 16'h0000, 16'h007E, FC_READ_HOLDING | EXC_FLAG, 0, 12);
    exp = {EXC_ILLEGAL_ADDR};
    xact(FC_WRITE_COIL, 16'h0010, COIL_ON, FC_WRITE_COIL | EXC_FLAG, 1, 12);
    check(coilState, 16'hA5C3);
    exp.delete();
    xact(FC_READ_COILS, 16'h0000, 16'h0001, FC_READ_COILS, 0, 7);
    bits_exp(16'hA5C3, 0, 1);
    xact(FC_READ_COILS, 16'h0000, 16'h0001, FC_READ_COILS, 0, 12);
  endtask : t_exc
  // ****
  // main sequence and watchdog
  // ****
  initial begin
    rst = 1'b1;
    coilWrEn = 1'b0;
    coilWrAddr = 16'h0000;
    coilWrData = 1'b0;
    hrWrEn = 1'b0;
    hrWrAddr = 16'h0000;
    hrWrData = 16'h0000;
    diState = 16'h0000;
    irState = '0;
    hrExp = '0;
    txn = 16'h0000;
    miscompares = 0;
    checks = 0;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    t_coils();
    t_inputs();
    t_regs();
    t_wcoil();
    t_exc();
    print_verdict();
  end
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
endmodule : testbench
bind mbsrv_server mbsrv_chk #(.N_COILS(N_COILS)) i_chk (.mclk(mclk), .rst(rst),
  .rxValid(rxValid), .rxLast(rxLast), .rxReady(rxReady), .txValid(txValid), .txData(txData),
  .txLast(txLast), .txReady(txReady), .coilState(coilState), .coilWrEn(coilWrEn),
  .coilWrAddr(coilWrAddr), .coilWrData(coilWrData));
